// >>> rtl/pdp_consts.svh
// constants for the protocol receive and hard reset block
`ifndef PDP_CONSTS_SVH
`define PDP_CONSTS_SVH
`define PDP_MSGID_W 3
`define PDP_HDR_W 16
`define PDP_MSGID_LSB 9
`define PDP_FIFO_DEPTH 16
`define PDP_FIFO_AW 4
// completion timer, least time in microseconds
`define PDP_HRC_TIME_US 5
`define PDP_CLK_MHZ 250
`define PDP_HRC_CYCLES (`PDP_HRC_TIME_US * `PDP_CLK_MHZ)
`define PDP_TMR_W 12
`define PDP_MSGID_RST 3'h0
`endif

// >>> rtl/pdp_fifo.sv
// flop based fifo with valid and ready on both sides
module pdp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_r;
    logic [AW:0] rdPtr_r;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_r != rdPtr_r;
    assign outData = mem[rdPtr_r[AW-1:0]];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // storage, no reset needed on data
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    // pointers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule

// >>> rtl/pdp_pkg.sv
// types for the protocol receive and hard reset block
package pdp_pkg;
    typedef enum logic [2:0] {
        RX_WAIT, RX_SEND_ACK, RX_CHECK_ID, RX_STORE_ID, RX_DELIVER
    } pdp_rx_e;
    typedef enum logic [2:0] {
        HR_IDLE, HR_RESET_LAYER, HR_INDICATE, HR_REQUEST, HR_WAIT_PHY,
        HR_PHY_REQUESTED, HR_WAIT_PE, HR_COMPLETE
    } pdp_hr_e;
endpackage

// >>> rtl/pdp_prl_rx_hr.sv
// protocol layer receive path and hard/cable reset sequencer
`include "pdp_consts.svh"
module pdp_prl_rx_hr
    import pdp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic isCablePlug,
    input wire logic phyRxValid,
    input wire logic [`PDP_HDR_W-1:0] phyRxHeader,
    input wire logic phyRxIsPing,
    input wire logic phyRxForPlug,
    input wire logic phyAckTaken,
    input wire logic phyDiscardIdle,
    input wire logic phyHardResetSeen,
    input wire logic phyCableResetSeen,
    input wire logic phyResetDone,
    input wire logic peHardResetReq,
    input wire logic peCableResetReq,
    input wire logic peResetDone,
    input wire logic peRxReady,
    output logic phyAckSend,
    output logic [`PDP_MSGID_W-1:0] phyAckMsgId,
    output logic phyResetSend,
    output logic phyResetIsCable,
    output logic phyResetFinished,
    output logic phyResetCancel,
    output logic phyChannelOff,
    output logic txDiscardReq,
    output logic txLayerReset,
    output logic msgIdCounterClear,
    output logic [`PDP_HDR_W-1:0] peRxHeader,
    output logic peRxValid,
    output logic peResetIndicate,
    output logic peResetIsCable,
    output logic peResetRequested,
    output logic plugMsgBlocked
);
    pdp_rx_e rxState_r;
    pdp_hr_e hrState_r;
    logic [`PDP_HDR_W-1:0] rxHeader_r;
    logic rxPing_r;
    logic [`PDP_MSGID_W-1:0] storedId_r;
    logic storedValid_r;
    logic fromPe_r;
    logic isCable_r;
    logic pending_r;
    logic [`PDP_TMR_W-1:0] timer_r;
    logic hardSeen;
    logic cableSeen;
    logic trigger;
    logic [`PDP_MSGID_W-1:0] rxId;
    logic fifoInReady;
    logic fifoInValid;
    logic [`PDP_HDR_W-1:0] fifoOutData;
    logic fifoOutValid;
    logic hrActive;
    logic hrBusy;
    logic fifoOutReady;

    // reset signaling from the line arrives asynchronously
    pdp_sync uSyncHard (
        .mclk(mclk),
        .rst(rst),
        .din(phyHardResetSeen),
        .dout(hardSeen)
    );
    pdp_sync uSyncCable (
        .mclk(mclk),
        .rst(rst),
        .din(phyCableResetSeen),
        .dout(cableSeen)
    );

    // delivered messages queue toward the policy engine
    pdp_fifo #(
        .WIDTH(`PDP_HDR_W),
        .DEPTH(`PDP_FIFO_DEPTH),
        .AW(`PDP_FIFO_AW)
    ) uRxFifo (
        .mclk(mclk),
        .rst(rst),
        .inData(rxHeader_r),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady)
    );

    assign rxId = rxHeader_r[`PDP_MSGID_LSB +: `PDP_MSGID_W];
    assign hrBusy = hrState_r != HR_IDLE;
    // plugs never start resets; cable signaling is for plugs only
    // any trigger enters layer reset from any state
    assign trigger = (!isCablePlug && (peHardResetReq || peCableResetReq))
        || hardSeen || (isCablePlug && cableSeen);
    // hard reset silences all traffic; cable reset only plug traffic
    assign hrActive = hrBusy && !isCable_r;
    // deliver stage holds until the queue takes it, stalling receive
    assign fifoInValid = rxState_r == RX_DELIVER;
    // pop only into an empty output stage, so no entry is lost unseen
    assign fifoOutReady = !peRxValid;

    // receive state machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxState_r <= RX_WAIT;
        end else if (trigger || hrActive) begin
            rxState_r <= RX_WAIT;
        end else begin
            case (rxState_r)
                RX_WAIT: begin
                    // drop plug traffic while cable reset runs
                    if (phyRxValid && !(hrBusy && phyRxForPlug)) begin
                        rxState_r <= RX_SEND_ACK;
                    end
                end
                RX_SEND_ACK: begin
                    // ack handed over, check id next
                    // discard after idle: take the check path
                    if (phyAckTaken || phyDiscardIdle) begin
                        rxState_r <= RX_CHECK_ID;
                    end
                end
                RX_CHECK_ID: begin
                    // compare only against a stored value
                    if (storedValid_r && storedId_r == rxId) begin
                        rxState_r <= RX_WAIT;
                    end else begin
                        rxState_r <= RX_STORE_ID;
                    end
                end
                RX_STORE_ID: begin
                    rxState_r <= RX_DELIVER;
                end
                RX_DELIVER: begin
                    if (fifoInReady) begin
                        rxState_r <= RX_WAIT;
                    end
                end
                default: begin
                    rxState_r <= RX_WAIT;
                end
            endcase
        end
    end

    // capture of the received header
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxHeader_r <= '0;
            rxPing_r <= 1'b0;
        end else if (rxState_r == RX_WAIT && phyRxValid) begin
            rxHeader_r <= phyRxHeader;
            rxPing_r <= phyRxIsPing;
        end
    end

    // stored id with its own valid flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            storedId_r <= `PDP_MSGID_RST;
            storedValid_r <= 1'b0;
        end else if (trigger) begin
            storedValid_r <= 1'b0;
        end else if (rxState_r == RX_STORE_ID) begin
            storedId_r <= rxId;
            storedValid_r <= 1'b1;
        end
    end

    // receive side outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phyAckSend <= 1'b0;
            phyAckMsgId <= '0;
            txDiscardReq <= 1'b0;
            peRxValid <= 1'b0;
            peRxHeader <= '0;
        end else begin
            // ask the PHY for GoodCRC echoing the id
            phyAckSend <= rxState_r == RX_SEND_ACK && !phyAckTaken
                && !phyDiscardIdle && !trigger;
            phyAckMsgId <= rxId;
            // force transmit discard, never for a ping
            txDiscardReq <= rxState_r == RX_CHECK_ID && !trigger
                && !(storedValid_r && storedId_r == rxId) && !rxPing_r;
            // output stage: load when empty, drop for a cycle after accept
            if (!peRxValid && fifoOutValid) begin
                peRxValid <= 1'b1;
                peRxHeader <= fifoOutData;
            end else if (peRxValid && peRxReady) begin
                peRxValid <= 1'b0;
            end
        end
    end

    // hard and cable reset sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrState_r <= HR_IDLE;
        end else if (trigger) begin
            hrState_r <= HR_RESET_LAYER;
        end else begin
            case (hrState_r)
                HR_IDLE: begin
                    hrState_r <= HR_IDLE;
                end
                HR_RESET_LAYER: begin
                    hrState_r <= fromPe_r ? HR_REQUEST : HR_INDICATE;
                end
                HR_INDICATE: begin
                    hrState_r <= HR_WAIT_PE;
                end
                HR_REQUEST: begin
                    hrState_r <= HR_WAIT_PHY;
                end
                HR_WAIT_PHY: begin
                    if (phyResetDone || timer_r == '0) begin
                        hrState_r <= HR_PHY_REQUESTED;
                    end
                end
                HR_PHY_REQUESTED: begin
                    hrState_r <= HR_WAIT_PE;
                end
                HR_WAIT_PE: begin
                    // hold until the policy engine finishes
                    if (peResetDone) begin
                        hrState_r <= HR_COMPLETE;
                    end
                end
                HR_COMPLETE: begin
                    hrState_r <= HR_IDLE;
                end
                default: begin
                    hrState_r <= HR_IDLE;
                end
            endcase
        end
    end

    // origin and kind of the reset, hard wins if both arrive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fromPe_r <= 1'b0;
            isCable_r <= 1'b0;
        end else if (trigger) begin
            fromPe_r <= !isCablePlug && (peHardResetReq || peCableResetReq);
            isCable_r <= !(hardSeen || (!isCablePlug && peHardResetReq));
        end
    end

    // completion timer, loaded on request, counts down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_r <= '0;
        end else if (hrState_r == HR_REQUEST) begin
            timer_r <= `PDP_TMR_W'(`PDP_HRC_CYCLES - 1);
        end else if (hrState_r == HR_WAIT_PHY && timer_r != '0) begin
            timer_r <= timer_r - 1'b1;
        end
    end

    // expiry leaves signaling pending until PE completes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending_r <= 1'b0;
        end else if (hrState_r == HR_WAIT_PHY && !phyResetDone
            && timer_r == '0) begin
            pending_r <= 1'b1;
        end else if (hrState_r == HR_COMPLETE || trigger) begin
            pending_r <= 1'b0;
        end
    end

    // reset sequencer outputs, one-cycle pulses except levels noted
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phyResetSend <= 1'b0;
            phyResetIsCable <= 1'b0;
            phyResetFinished <= 1'b0;
            phyResetCancel <= 1'b0;
            phyChannelOff <= 1'b0;
            txLayerReset <= 1'b0;
            msgIdCounterClear <= 1'b0;
            peResetIndicate <= 1'b0;
            peResetIsCable <= 1'b0;
            peResetRequested <= 1'b0;
            plugMsgBlocked <= 1'b0;
        end else begin
            // clear counter and reset transmit machine
            msgIdCounterClear <= hrState_r == HR_RESET_LAYER;
            txLayerReset <= hrState_r == HR_RESET_LAYER;
            phyResetSend <= hrState_r == HR_REQUEST;
            phyResetIsCable <= isCable_r;
            peResetIsCable <= isCable_r;
            peResetIndicate <= hrState_r == HR_INDICATE;
            // tell PE the PHY was asked
            peResetRequested <= hrState_r == HR_PHY_REQUESTED;
            // tell the PHY the reset is done
            phyResetFinished <= hrState_r == HR_COMPLETE;
            phyResetCancel <= hrState_r == HR_COMPLETE && pending_r;
            // channel off through a hard reset
            phyChannelOff <= hrState_r != HR_IDLE
                && hrState_r != HR_COMPLETE && !isCable_r;
            // cable reset blocks plug traffic only
            plugMsgBlocked <= hrState_r != HR_IDLE
                && hrState_r != HR_COMPLETE && isCable_r;
        end
    end
endmodule

// >>> rtl/pdp_sync.sv
// two-stage synchroniser for one level from outside the clock domain
module pdp_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_r;

    // first stage is read only by the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// >>> test/pdp_phy_model.sv
// phy side model answering ack and reset signaling requests
module pdp_phy_model (
    input wire logic mclk,
    input wire logic phyAckSend,
    input wire logic phyResetSend,
    input wire logic useIdle,
    input wire logic mute,
    input wire logic [3:0] lag,
    output logic phyAckTaken,
    output logic phyDiscardIdle,
    output logic phyResetDone
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        phyAckTaken = 0;
        phyDiscardIdle = 0;
        phyResetDone = 0;
    end
    // answer ack after lag, taken or discarded
    always @(posedge mclk) begin
        if (phyAckSend === 1'b1) begin
            repeat (lag) @(posedge mclk);
            #1;
            if (useIdle) phyDiscardIdle = 1;
            else phyAckTaken = 1;
            @(posedge mclk);
            #1;
            phyAckTaken = 0;
            phyDiscardIdle = 0;
        end
    end
    // completion pulse, muted models a busy channel
    always @(posedge mclk) begin
        if (phyResetSend === 1'b1 && !mute) begin
            repeat (lag) @(posedge mclk);
            #1;
            phyResetDone = 1;
            @(posedge mclk);
            #1;
            phyResetDone = 0;
        end
    end
endmodule

// >>> test/pdp_prl_asserts.sv
// port checker for the receive path and reset sequencer
`include "pdp_consts.svh"
module pdp_prl_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic isCablePlug,
    input wire logic phyRxValid,
    input wire logic phyAckTaken,
    input wire logic phyDiscardIdle,
    input wire logic peHardResetReq,
    input wire logic peResetDone,
    input wire logic phyAckSend,
    input wire logic txDiscardReq,
    input wire logic txLayerReset,
    input wire logic msgIdCounterClear,
    input wire logic phyResetSend,
    input wire logic peResetIndicate,
    input wire logic phyResetFinished,
    input wire logic phyResetCancel,
    input wire logic phyChannelOff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ack only follows a received message
    AST_ACK_START: assert property ($rose(phyAckSend) |->
        $past(phyRxValid, 2) || $past(phyRxValid, 3))
        else $error("ack request without a message");
    // ack request withdrawn once answered
    AST_ACK_END: assert property (
        phyAckSend && (phyAckTaken || phyDiscardIdle) |=> !phyAckSend)
        else $error("ack request held after answer");
    // discard follows an answered ack
    AST_DISCARD: assert property (txDiscardReq |->
        $past(phyAckTaken, 2) || $past(phyDiscardIdle, 2) ||
        $past(phyAckTaken, 3) || $past(phyDiscardIdle, 3))
        else $error("discard without new message");
    // layer reset on a policy engine hard reset request
    AST_LAYER_CLEAR: assert property (
        peHardResetReq && !isCablePlug |->
        ##[2:3] (msgIdCounterClear && txLayerReset))
        else $error("layer reset missing");
    // signaling request only after layer reset, never in a plug
    AST_REQ_SEND: assert property (phyResetSend |->
        $past(txLayerReset) && !isCablePlug)
        else $error("reset signaling request out of place");
    // indication only after layer reset
    AST_INDICATE: assert property (peResetIndicate |->
        $past(txLayerReset))
        else $error("indication out of place");
    // finish follows the policy engine completion
    AST_FINISH: assert property (phyResetFinished |->
        $past(peResetDone, 2) || $past(peResetDone, 3))
        else $error("finish without completion");
    // cancel comes only with finish
    AST_CANCEL: assert property (phyResetCancel |->
        phyResetFinished)
        else $error("cancel without finish");
    // no ack once the channel has been off for three cycles
    AST_CHAN_OFF: assert property (phyChannelOff [*3] |->
        !phyAckSend)
        else $error("ack during hard reset");
endmodule

bind pdp_prl_rx_hr pdp_prl_asserts pdp_prl_asserts_i (.mclk, .rst,
    .isCablePlug, .phyRxValid, .phyAckTaken, .phyDiscardIdle,
    .peHardResetReq, .peResetDone, .phyAckSend, .txDiscardReq,
    .txLayerReset, .msgIdCounterClear, .phyResetSend, .peResetIndicate,
    .phyResetFinished, .phyResetCancel, .phyChannelOff);

// >>> test/tb_top.sv
// self-checking bench for the receive path and reset sequencer
`include "pdp_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, isCablePlug, phyRxValid, phyRxIsPing, phyRxForPlug;
    logic phyAckTaken, phyDiscardIdle, phyHardResetSeen, phyCableResetSeen;
    logic phyResetDone, peHardResetReq, peCableResetReq, peResetDone;
    logic peRxReady, phyAckSend, phyResetSend, phyResetIsCable;
    logic phyResetFinished, phyResetCancel, phyChannelOff, txDiscardReq;
    logic txLayerReset, msgIdCounterClear, peRxValid, peResetIndicate;
    logic peResetIsCable, peResetRequested, plugMsgBlocked, useIdle, mute;
    logic [`PDP_MSGID_W-1:0] phyAckMsgId;
    logic [`PDP_HDR_W-1:0] phyRxHeader, peRxHeader;
    logic [`PDP_HDR_W-1:0] expQ[$];
    logic [3:0] lag;
    int err_total, cmp_count, discCnt, n;

    pdp_prl_rx_hr pdp_prl_rx_hr_i (.mclk, .rst, .isCablePlug, .phyRxValid,
        .phyRxHeader, .phyRxIsPing, .phyRxForPlug, .phyAckTaken,
        .phyDiscardIdle, .phyHardResetSeen, .phyCableResetSeen,
        .phyResetDone, .peHardResetReq, .peCableResetReq, .peResetDone,
        .peRxReady, .phyAckSend, .phyAckMsgId, .phyResetSend,
        .phyResetIsCable, .phyResetFinished, .phyResetCancel,
        .phyChannelOff, .txDiscardReq, .txLayerReset, .msgIdCounterClear,
        .peRxHeader, .peRxValid, .peResetIndicate, .peResetIsCable,
        .peResetRequested, .plugMsgBlocked);
    pdp_phy_model pdp_phy_model_i (.mclk, .phyAckSend, .phyResetSend,
        .useIdle, .mute, .lag, .phyAckTaken, .phyDiscardIdle,
        .phyResetDone);

    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_hdr(input logic [`PDP_HDR_W-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t header %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic ev(input int k);
        case (k)
            0: return phyAckSend;
            1: return peResetRequested;
            2: return peResetIndicate;
            3: return phyResetFinished;
            4: return phyResetSend;
            default: return !phyAckSend;
        endcase
    endfunction
    // bounded wait; n keeps the cycles spent
    task automatic wait_ev(input int k, input int lim);
        n = 0;
        while (ev(k) !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= lim) begin
            err_total++;
            $display("Error %0t wait %0d timed out", $time, k);
            finish_test();
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // message held until the ack request shows it was taken
    task automatic send(input logic [2:0] id, input logic ping, exp);
        logic [`PDP_HDR_W-1:0] h;
        h = `PDP_HDR_W'($urandom);
        h[`PDP_MSGID_LSB +: `PDP_MSGID_W] = id;
        phyRxHeader = h;
        phyRxIsPing = ping;
        phyRxValid = 1;
        if (exp) expQ.push_back(h);
        wait_ev(0, 60);
        cmp_hdr(`PDP_HDR_W'(phyAckMsgId), `PDP_HDR_W'(id));
        phyRxValid = 0;
        wait_ev(5, 40);
        tick(4);
    endtask
    task automatic pe_done(input logic cancel);
        peResetDone = 1;
        tick(1);
        peResetDone = 0;
        wait_ev(3, 6);
        cmp_bit(phyResetCancel, cancel);
    endtask

    // reader side: oldest note against each accepted header
    always @(posedge mclk) begin
        if (txDiscardReq === 1'b1) discCnt++;
        if (peRxValid === 1'b1 && peRxReady === 1'b1) begin
            if (expQ.size() == 0) begin
                err_total++;
                $display("Error %0t unexpected delivery", $time);
            end else cmp_hdr(peRxHeader, expQ.pop_front());
        end
    end

    initial begin
        {rst, isCablePlug, phyRxValid, phyRxIsPing, phyRxForPlug} = 5'h10;
        {phyHardResetSeen, phyCableResetSeen, peHardResetReq} = 3'h0;
        {peCableResetReq, peResetDone, peRxReady, useIdle, mute} = 5'h0;
        phyRxHeader = '0;
        lag = 4'h2;
        void'($urandom(86300));
        repeat (8) @(posedge mclk);
        #1;
        rst = 0;
        peRxReady = 1;
        tick(2);
        // first, retry, new, then ping which skips the discard
        send(3'h5, 0, 1);
        send(3'h5, 0, 0);
        send(3'h2, 0, 1);
        send(3'h3, 1, 1);
        cmp_bit(discCnt == 2, 1);
        // discarded-then-idle answer still delivers
        useIdle = 1;
        send(3'h4, 0, 1);
        useIdle = 0;
        // reader stalled while the buffer fills, phy lag random
        peRxReady = 0;
        for (int i = 0; i < `PDP_FIFO_DEPTH; i++) begin
            lag = 4'($urandom_range(0, 6));
            send(3'(i), 0, 1);
        end
        cmp_bit(peRxValid, 1);
        peRxReady = 1;
        tick(40);
        cmp_bit(peRxValid, 0);
        // policy engine hard reset, phy answers
        peHardResetReq = 1;
        tick(1);
        peHardResetReq = 0;
        wait_ev(4, 10);
        cmp_bit(phyResetIsCable, 0);
        cmp_bit(phyChannelOff, 1);
        wait_ev(1, 40);
        pe_done(0);
        // stored id forgotten after reset
        send(3'h7, 0, 1);
        // cable reset with a busy channel, timer expires
        mute = 1;
        peCableResetReq = 1;
        tick(1);
        peCableResetReq = 0;
        wait_ev(4, 10);
        cmp_bit(phyResetIsCable, 1);
        cmp_bit(plugMsgBlocked, 1);
        wait_ev(1, 1400);
        cmp_bit(n >= `PDP_HRC_CYCLES - 2 && n <= `PDP_HRC_CYCLES + 6, 1);
        // plug traffic refused during cable reset, other traffic flows
        phyRxForPlug = 1;
        phyRxValid = 1;
        tick(1);
        {phyRxValid, phyRxForPlug} = 2'h0;
        tick(2);
        cmp_bit(phyAckSend, 0);
        send(3'h1, 0, 1);
        mute = 0;
        pe_done(1);
        // hard reset signaled by the phy, message ignored meanwhile
        phyHardResetSeen = 1;
        tick(3);
        phyHardResetSeen = 0;
        wait_ev(2, 10);
        cmp_bit(peResetIsCable, 0);
        phyRxValid = 1;
        tick(1);
        phyRxValid = 0;
        tick(8);
        cmp_bit(phyAckSend, 0);
        pe_done(0);
        // cable plug ignores requests, recognises cable signaling
        isCablePlug = 1;
        tick(2);
        peHardResetReq = 1;
        tick(1);
        peHardResetReq = 0;
        tick(10);
        cmp_bit(phyChannelOff, 0);
        phyCableResetSeen = 1;
        tick(3);
        phyCableResetSeen = 0;
        wait_ev(2, 10);
        cmp_bit(peResetIsCable, 1);
        pe_done(0);
        cmp_bit(expQ.size() == 0, 1);
        finish_test();
    end
endmodule
